// ==== verilog/ccd_regs.svh ====
`ifndef CCD_REGS_SVH
`define CCD_REGS_SVH
// ----------------------------------------
// Opcode patterns
// ----------------------------------------
`define CCD_OP_CLRACC   14'h0140
`define CCD_OP_WDCLR    14'h0004
`define CCD_OPC_COMP    6'h09
`define CCD_OPC_DEC     6'h03
`define CCD_OPC_DECSKIP 6'h0b
// ----------------------------------------
// Field positions and limits
// ----------------------------------------
`define CCD_OPC_MSB     13
`define CCD_OPC_LSB     8
`define CCD_DEST_BIT    7
`define CCD_FILE_MAX    7'h5f
`define CCD_ZERO_BYTE   8'h00
// ----------------------------------------
// Reset values
// ----------------------------------------
`define CCD_BYTE_RESET  8'h00
`define CCD_ADDR_RESET  7'h00
`define CCD_FLAG_RESET  1'b1
`endif

// ==== verilog/ccd_pkg.sv ====
package ccd_pkg;
  typedef enum logic [5:0] {
    CCD_NONE    = 6'h01,
    CCD_CLRACC  = 6'h02,
    CCD_WDCLR   = 6'h04,
    CCD_COMP    = 6'h08,
    CCD_DEC     = 6'h10,
    CCD_DECSKIP = 6'h20
  } ccd_op_type;
endpackage

// ==== verilog/ccd_decode.sv ====
`timescale 1ns/1ps
`include "ccd_regs.svh"
module ccd_decode (
  input  wire logic [13:0]        instr,
  output ccd_pkg::ccd_op_type     op,
  output logic                    operandOk
);
  import ccd_pkg::*;
  // Classify the instruction word
  always_comb begin
    op = CCD_NONE;
    if (instr == `CCD_OP_CLRACC) begin
      op = CCD_CLRACC;
    end else if (instr == `CCD_OP_WDCLR) begin
      op = CCD_WDCLR;
    end else if (instr[`CCD_OPC_MSB:`CCD_OPC_LSB] == `CCD_OPC_COMP) begin
      op = CCD_COMP;
    end else if (instr[`CCD_OPC_MSB:`CCD_OPC_LSB] == `CCD_OPC_DEC) begin
      op = CCD_DEC;
    end else if (instr[`CCD_OPC_MSB:`CCD_OPC_LSB] == `CCD_OPC_DECSKIP) begin
      op = CCD_DECSKIP;
    end
  end
  // File address within the data memory range
  assign operandOk = (instr[6:0] <= `CCD_FILE_MAX);
endmodule // ccd_decode

// ==== verilog/ccd_exec.sv ====
`timescale 1ns/1ps
`include "ccd_regs.svh"
module ccd_exec #(
  parameter int DATA_WIDTH = 8
) (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  input  wire logic                  instrValid,
  input  wire logic [13:0]           instr,
  input  wire logic [DATA_WIDTH-1:0] fileData,
  output logic      [DATA_WIDTH-1:0] accumulator,
  output logic                       zeroFlag,
  output logic                       timeOutFlag,
  output logic                       powerDownFlag,
  output logic                       watchdogClear,
  output logic                       fileWrite,
  output logic      [6:0]            fileAddr,
  output logic      [DATA_WIDTH-1:0] fileWriteData,
  output logic                       skipNext,
  output logic                       operandError
);
  import ccd_pkg::*;

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Datapath width is fixed by the opcode format
  if (DATA_WIDTH != 8) begin : g_width_check
    $error("ccd_exec serves only an 8-bit datapath");
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  ccd_op_type op;
  logic       operandOk;
  ccd_decode u_decode (
    .instr     (instr),
    .op        (op),
    .operandOk (operandOk)
  );

  function automatic logic isZero(input logic [DATA_WIDTH-1:0] v);
    return v == `CCD_ZERO_BYTE;
  endfunction

  logic                  dest;
  logic                  fileOp;
  logic                  squash;
  logic                  active;
  logic                  skipHit;
  logic [DATA_WIDTH-1:0] result;
  assign dest   = instr[`CCD_DEST_BIT];
  assign fileOp = (op == CCD_COMP) || (op == CCD_DEC) || (op == CCD_DECSKIP);
  // Squashed slot executes as no-operation
  assign active = instrValid && !squash;
  // Decrement-and-skip landed on zero
  assign skipHit = active && op == CCD_DECSKIP && operandOk && isZero(result);

  // Result of the file operations
  always_comb begin
    result = fileData - 8'h01;
    if (op == CCD_COMP) begin
      result = ~fileData;
    end
  end

  // ----------------------------------------
  // Accumulator and zero flag
  // ----------------------------------------
  // Accumulator load
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      accumulator <= `CCD_BYTE_RESET;
    end else if (active && op == CCD_CLRACC) begin
      accumulator <= `CCD_ZERO_BYTE;
    end else if (active && fileOp && operandOk && !dest) begin
      accumulator <= result;
    end
  end

  // Zero flag, untouched by decrement-and-skip
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      zeroFlag <= 1'b0;
    end else if (active && op == CCD_CLRACC) begin
      zeroFlag <= 1'b1;
    end else if (active && operandOk && (op == CCD_COMP || op == CCD_DEC)) begin
      zeroFlag <= isZero(result);
    end
  end

  // ----------------------------------------
  // Watchdog service
  // ----------------------------------------
  // Clear pulse and status flags
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      watchdogClear <= 1'b0;
      timeOutFlag   <= `CCD_FLAG_RESET;
      powerDownFlag <= `CCD_FLAG_RESET;
    end else begin
      watchdogClear <= active && op == CCD_WDCLR;
      if (active && op == CCD_WDCLR) begin
        timeOutFlag   <= 1'b1;
        powerDownFlag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // File write-back and skip
  // ----------------------------------------
  // Write port to the register file
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fileWrite     <= 1'b0;
      fileAddr      <= `CCD_ADDR_RESET;
      fileWriteData <= `CCD_BYTE_RESET;
    end else begin
      fileWrite     <= active && fileOp && operandOk && dest;
      fileAddr      <= instr[6:0];
      fileWriteData <= result;
    end
  end

  // Skip marker for the following slot
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      squash   <= 1'b0;
      skipNext <= 1'b0;
    end else begin
      if (instrValid) begin
        squash <= skipHit;
      end
      skipNext <= skipHit;
    end
  end

  // Out-of-range file operand
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      operandError <= 1'b0;
    end else begin
      operandError <= active && fileOp && !operandOk;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Clear accumulator leaves zero and a set flag
  chk_clracc_zero: assert property (@(posedge clk) disable iff (!resetn)
    (instrValid && !squash && instr == `CCD_OP_CLRACC) |=> (accumulator == 8'h00 && zeroFlag))
    else $error("clear accumulator failed");
  // Clear accumulator never touches the file
  chk_clracc_nowrite: assert property (@(posedge clk) disable iff (!resetn)
    (instrValid && !squash && instr == `CCD_OP_CLRACC) |=> (!fileWrite && !operandError))
    else $error("clear accumulator wrote file");
  // Watchdog service pulse and status flags
  chk_wdclr_flags: assert property (@(posedge clk) disable iff (!resetn)
    (instrValid && !squash && instr == `CCD_OP_WDCLR) |=> (watchdogClear && timeOutFlag && powerDownFlag))
    else $error("watchdog clear failed");
  // No clear pulse without the opcode
  chk_wdclr_quiet: assert property (@(posedge clk) disable iff (!resetn)
    !(instrValid && !squash && instr == `CCD_OP_WDCLR) |=> !watchdogClear)
    else $error("spurious watchdog clear");
  // Complement written back
  chk_comp_value: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_COMP && operandOk && dest) |=> (fileWriteData == ~$past(fileData)))
    else $error("complement value wrong");
  // Complement zero flag follows an all-ones operand
  chk_comp_zero: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_COMP && operandOk) |=> (zeroFlag == ($past(fileData) == 8'hff)))
    else $error("complement zero flag wrong");
  // Accumulator destination leaves the file alone
  chk_dest_acc: assert property (@(posedge clk) disable iff (!resetn)
    (active && fileOp && operandOk && !dest) |=> (!fileWrite && accumulator == $past(result)))
    else $error("accumulator destination wrong");
  // File destination keeps the accumulator
  chk_dest_file: assert property (@(posedge clk) disable iff (!resetn)
    (active && fileOp && operandOk && dest) |=>
      (fileWrite && fileAddr == $past(instr[6:0]) && $stable(accumulator)))
    else $error("file destination wrong");
  // Decrement written back
  chk_dec_value: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_DEC && operandOk && dest) |=> (fileWrite && fileWriteData == $past(fileData) - 8'h01))
    else $error("decrement value wrong");
  // Skip decrement leaves the zero flag alone
  chk_skip_noflag: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_DECSKIP) |=> $stable(zeroFlag))
    else $error("skip decrement touched flag");
  // Zero result squashes the next slot
  chk_skip_squash: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_DECSKIP && operandOk && fileData == 8'h01) |=> (skipNext && squash))
    else $error("skip not taken");
  // Nonzero result runs on without a skip
  chk_skip_nonzero: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_DECSKIP && operandOk && fileData != 8'h01) |=> !skipNext)
    else $error("skip taken on nonzero");
  // Squashed slot has no effect at all
  chk_squash_noop: assert property (@(posedge clk) disable iff (!resetn)
    (instrValid && squash) |=>
      (!fileWrite && !watchdogClear && !operandError && $stable(accumulator) && $stable(zeroFlag)))
    else $error("squashed slot executed");
  // Writes stay inside the data memory
  chk_range_write: assert property (@(posedge clk) disable iff (!resetn)
    fileWrite |-> (fileAddr <= `CCD_FILE_MAX))
    else $error("write outside file range");
  // Out-of-range operand is refused
  chk_range_error: assert property (@(posedge clk) disable iff (!resetn)
    (active && fileOp && !operandOk) |=> (operandError && !fileWrite && $stable(accumulator)))
    else $error("out-of-range operand executed");
  // Decrement zero flag
  chk_zero_flag: assert property (@(posedge clk) disable iff (!resetn)
    (active && op == CCD_DEC && operandOk) |=> (zeroFlag == ($past(fileData) == 8'h01)))
    else $error("zero flag wrong");
endmodule // ccd_exec

// ==== dv/ccd_core_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Register file and watchdog partner
// ----------------------------------------
module ccd_core_model (
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [6:0] rdAddr,
  output logic      [7:0] rdData,
  input  wire logic       wrEn,
  input  wire logic [6:0] wrAddr,
  input  wire logic [7:0] wrData,
  input  wire logic       wdClear
);
  logic [7:0] mem [0:127];
  logic [7:0] wdCount;
  logic [7:0] wkCount;
  // Same-cycle read of the addressed register
  assign rdData = mem[rdAddr];
  // Write-back port
  always @(posedge clk) begin
    if (wrEn) mem[wrAddr] <= wrData;
  end
  // Watchdog and wake-up counters, free running until cleared
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wdCount <= 8'h00;
      wkCount <= 8'h00;
    end else begin
      wdCount <= wdClear ? 8'h00 : wdCount + 8'h01;
      wkCount <= wdClear ? 8'h00 : wkCount + 8'h01;
    end
  end
endmodule // ccd_core_model

// ==== dv/clear_complement_decrement_exec_tb_top.sv ====
`timescale 1ns/1ps
module clear_complement_decrement_exec_tb_top;
  import ccd_pkg::*;
  logic clk, resetn, instrValid, zeroFlag, timeOutFlag, powerDownFlag;
  logic watchdogClear, fileWrite, skipNext, operandError;
  logic [13:0] instr;
  logic [7:0]  fileData, accumulator, fileWriteData;
  logic [6:0]  fileAddr;
  int          err_total, check_count;
  // Clock generation; reset is driven by the main sequence
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ccd_exec #(.DATA_WIDTH(8)) dut (.clk, .resetn, .instrValid, .instr, .fileData, .accumulator, .zeroFlag,
    .timeOutFlag, .powerDownFlag, .watchdogClear, .fileWrite, .fileAddr, .fileWriteData, .skipNext, .operandError);
  ccd_core_model rf (.clk, .resetn, .rdAddr(instr[6:0]), .rdData(fileData), .wrEn(fileWrite),
    .wrAddr(fileAddr), .wrData(fileWriteData), .wdClear(watchdogClear));
  // Compare one byte-wide result
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Present one instruction slot; results settle after the taking edge
  task automatic run(input logic [13:0] w);
    @(posedge clk);
    instrValid <= 1'b1;
    instr <= w;
    @(posedge clk);
    instrValid <= 1'b0;
    #1;
  endtask
  task automatic t_comp;
    rf.mem[6] = 8'hff;
    run(14'h0906); chk(accumulator, 8'h00); chk({7'h00, zeroFlag}, 8'h01);
    rf.mem[5] = 8'h13;
    run(14'h0905); chk(accumulator, 8'hec); chk({7'h00, fileWrite}, 8'h00);
    chk({7'h00, zeroFlag}, 8'h00);
    run(14'h0985); chk({fileWrite, fileAddr}, 8'h85); chk(fileWriteData, 8'hec);
    chk(accumulator, 8'hec);
  endtask
  task automatic t_clracc;
    run(14'h0140); chk(accumulator, 8'h00); chk({7'h00, zeroFlag}, 8'h01);
  endtask
  task automatic t_wdclr;
    run(14'h0004); chk({5'h00, watchdogClear, timeOutFlag, powerDownFlag}, 8'h07);
    @(posedge clk); #1;
    chk({7'h00, watchdogClear}, 8'h00); chk(rf.wdCount, 8'h00); chk(rf.wkCount, 8'h00);
  endtask
  task automatic t_dec;
    rf.mem[7] = 8'h01;
    run(14'h0387); chk({fileWrite, fileAddr}, 8'h87); chk(fileWriteData, 8'h00);
    chk({7'h00, zeroFlag}, 8'h01);
    run(14'h0307); chk(accumulator, 8'hff); chk({7'h00, zeroFlag}, 8'h00);
  endtask
  task automatic t_skip;
    rf.mem[8] = 8'h03;
    rf.mem[9] = 8'h01;
    run(14'h0140);
    run(14'h0b08); chk(accumulator, 8'h02); chk({6'h00, skipNext, zeroFlag}, 8'h01);
    run(14'h0b89); chk(fileWriteData, 8'h00); chk({5'h00, skipNext, zeroFlag, fileWrite}, 8'h07);
    run(14'h0140); chk(accumulator, 8'h02);
    run(14'h0140); chk(accumulator, 8'h00);
  endtask
  task automatic t_range;
    run(14'h09e0); chk({6'h00, operandError, fileWrite}, 8'h02);
    rf.mem[95] = 8'h0f;
    run(14'h09df); chk({6'h00, operandError, fileWrite}, 8'h01);
    chk(fileWriteData, 8'hf0);
  endtask
  task automatic end_of_test;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Bound on the whole run
  initial begin
    repeat (2000) @(posedge clk);
    err_total++;
    end_of_test();
  end
  // Main sequence
  initial begin
    resetn = 1'b0;
    instrValid = 1'b0;
    instr = 14'h0000;
    err_total = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    t_comp();
    t_clracc();
    t_wdclr();
    t_dec();
    t_skip();
    t_range();
    end_of_test();
  end
endmodule // clear_complement_decrement_exec_tb_top
